// ---- core/mcm_main_clock_monitor.sv ----
// Purpose: main crystal failure detector, slow crystal monitor, main
//          oscillator control, frequency measure and pll setup
// Assumes: all oscillators arrive as pins far slower than clk_i
// Notes:   APB slave, one wait state on every access
`timescale 1ns/1ns
`default_nettype none
module mcm_main_clock_monitor (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   // apb slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // oscillator pins
   input  wire logic        crystal_clk_i,
   input  wire logic        fast_rc_clk_i,
   input  wire logic        rc32_clk_i,
   input  wire logic        slow_clk_i,
   input  wire logic        slow_crystal_clk_i,
   // master clock selector, same domain
   input  wire logic [1:0]  master_source_select_i,
   // oscillator and clock controls
   output logic             crystal_osc_enable_o,
   output logic             fast_rc_enable_o,
   output logic             rc32_enable_o,
   output logic             main_source_select_o,
   output logic             master_force_main_o,
   output logic             pll_enable_o,
   output logic      [6:0]  pll_input_divider_o,
   output logic      [6:0]  pll_multiplier_o,
   // fault and interrupt
   output logic             fault_output_o,
   output logic             irq_o
);
   import mcm_pkg::*;

   // ***************************************************
   // synchronised oscillator levels
   // ***************************************************
   logic [4:0] osc_sync;
   logic [4:0] osc_prev_reg;
   logic       xtal_rise, frc_rise, rc32_rise, rc32_fall, slow_rise, x32_rise;

   mcm_sync #(.W(5)) u_sync (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .async_i ({slow_crystal_clk_i, slow_clk_i, rc32_clk_i,
                 fast_rc_clk_i, crystal_clk_i}),
      .sync_o  (osc_sync)
   );

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) osc_prev_reg <= 5'h00;
      else          osc_prev_reg <= osc_sync;
   end

   assign xtal_rise = osc_sync[0] & ~osc_prev_reg[0];
   assign frc_rise  = osc_sync[1] & ~osc_prev_reg[1];
   assign rc32_rise = osc_sync[2] & ~osc_prev_reg[2];
   assign rc32_fall = ~osc_sync[2] & osc_prev_reg[2];
   assign slow_rise = osc_sync[3] & ~osc_prev_reg[3];
   assign x32_rise  = osc_sync[4] & ~osc_prev_reg[4];

   // ***************************************************
   // apb access decode
   // ***************************************************
   logic        acc_done, wr_en, rd_en;
   logic [31:0] osc_ctrl_reg, pll_cfg_reg, status_w;
   logic [31:0] int_en_reg, rd_mux;
   logic [2:0]  rc_cal_reg;
   logic        mapped;

   assign acc_done = psel_i & penable_i & pready_o;
   assign wr_en    = acc_done & pwrite_i;
   assign rd_en    = acc_done & ~pwrite_i;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   assign mapped = hit(paddr_i, OSC_CTRL_OFS) | hit(paddr_i, FREQ_MEAS_OFS)
                 | hit(paddr_i, PLL_CFG_OFS)  | hit(paddr_i, STATUS_OFS)
                 | hit(paddr_i, INT_EN_OFS)   | hit(paddr_i, FAULT_CLR_OFS)
                 | hit(paddr_i, RC_CAL_OFS);

   // ***************************************************
   // main oscillator control
   // ***************************************************
   logic fdet_on, fail_pulse, fail_force_master;
   logic xtal_en, frc_en, main_sel;

   assign xtal_en  = osc_ctrl_reg[XTAL_EN_BIT];
   assign frc_en   = osc_ctrl_reg[FRC_EN_BIT];
   assign main_sel = osc_ctrl_reg[MAIN_SEL_BIT];
   assign fdet_on  = osc_ctrl_reg[FDET_EN_BIT] & xtal_en;

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         osc_ctrl_reg <= OSC_CTRL_RST;
      end else begin
         if (wr_en && hit(paddr_i, OSC_CTRL_OFS)) osc_ctrl_reg <= pwdata_i;
         if (fail_pulse) begin
            osc_ctrl_reg[MAIN_SEL_BIT] <= 1'b0;
            osc_ctrl_reg[FRC_EN_BIT]   <= 1'b1;
         end
      end
   end

   // ***************************************************
   // main crystal failure detector
   // ***************************************************
   logic [3:0] edge_cnt_reg;
   logic       live_fail_reg, event_reg, fault_reg, force_main_reg;

   // saturating count, eight is all the decision needs
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) edge_cnt_reg <= 4'h0;
      else if (!fdet_on || !osc_sync[2]) edge_cnt_reg <= 4'h0;
      else if (xtal_rise && edge_cnt_reg != 4'hf)
         edge_cnt_reg <= edge_cnt_reg + 4'h1;
   end

   // decided on the falling rc edge, i.e. one rc period per check
   assign fail_pulse = fdet_on & rc32_fall
                     & (edge_cnt_reg < 4'(FAIL_MIN_EDGES));

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) live_fail_reg <= 1'b0;
      else if (!fdet_on) live_fail_reg <= 1'b0;
      else if (fail_pulse) live_fail_reg <= 1'b1;
      else if (rc32_fall) live_fail_reg <= 1'b0;
   end

   // set wins over the read clear
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) event_reg <= 1'b0;
      else if (fail_pulse) event_reg <= 1'b1;
      else if (rd_en && hit(paddr_i, STATUS_OFS)) event_reg <= 1'b0;
   end

   // clear needs the defect gone, so a stuck crystal keeps the pwm safe
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) fault_reg <= 1'b0;
      else if (fail_pulse) fault_reg <= 1'b1;
      else if (wr_en && hit(paddr_i, FAULT_CLR_OFS) && pwdata_i[FAULT_OUTPUT_CLEAR_BIT]
               && !live_fail_reg) fault_reg <= 1'b0;
   end

   assign fail_force_master = fail_pulse & main_sel
                            & (master_source_select_i == CSS_PLL);

   // held until the master selector leaves the pll
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) force_main_reg <= 1'b0;
      else if (fail_force_master) force_main_reg <= 1'b1;
      else if (master_source_select_i != CSS_PLL) force_main_reg <= 1'b0;
   end

   // ***************************************************
   // slow crystal frequency monitor
   // ***************************************************
   logic [10:0] x32_per_reg;
   logic [2:0]  x32_bad_reg;
   logic        x32_err_reg, x32_mon, x32_bad;

   assign x32_mon = osc_ctrl_reg[XT32_MON_BIT] & (rc_cal_reg == 3'h0);
   assign x32_bad = (x32_per_reg != 11'h000)
                  & ((x32_per_reg < 11'(XT32_MIN_CYC))
                  | (x32_per_reg > 11'(XT32_MAX_CYC)));

   always_ff @(posedge clk_i) begin
      if (!rst_b_i || !x32_mon) begin
         x32_per_reg <= 11'h000;
         x32_bad_reg <= 3'h0;
      end else if (x32_rise) begin
         x32_per_reg <= 11'h001;
         if (!x32_bad) x32_bad_reg <= 3'h0;
         else if (x32_bad_reg != 3'(XT32_BAD_RUNS))
            x32_bad_reg <= x32_bad_reg + 3'h1;
      end else if (x32_per_reg != 11'h000 && x32_per_reg != 11'h7ff) begin
         x32_per_reg <= x32_per_reg + 11'h001;
      end
   end

   // first partial period after enable is ignored by the count start
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) x32_err_reg <= 1'b0;
      else if (x32_mon && x32_bad_reg == 3'(XT32_BAD_RUNS))
         x32_err_reg <= 1'b1;
      else if (!osc_ctrl_reg[XT32_MON_BIT]) x32_err_reg <= 1'b0;
   end

   // ***************************************************
   // crystal start-up and source switch
   // ***************************************************
   logic [10:0] startup_cnt_reg;
   logic        xtal_ok_reg, switched_reg;

   always_ff @(posedge clk_i) begin
      if (!rst_b_i || !xtal_en) begin
         startup_cnt_reg <= 11'h000;
         xtal_ok_reg     <= 1'b0;
      end else if (slow_rise && !xtal_ok_reg) begin
         if (startup_cnt_reg >= 11'({osc_ctrl_reg[STARTUP_LSB +: 8], 3'h0}))
            xtal_ok_reg <= 1'b1;
         else startup_cnt_reg <= startup_cnt_reg + 11'h001;
      end
   end

   // crystal selection only counts once the oscillator is stable
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) switched_reg <= 1'b1;
      else switched_reg <= (main_sel == main_source_select_o)
                           & (~main_sel | xtal_ok_reg);
   end

   // ***************************************************
   // main clock frequency measurement
   // ***************************************************
   logic [15:0] meas_cnt_reg, freq_val_reg;
   logic [4:0]  meas_slow_reg;
   logic        freq_rdy_reg, main_edge, meas_run_reg;

   assign main_edge = main_source_select_o ? xtal_rise : frc_rise;

   // restart while main_sel and the select output differ, i.e. on a written source change but not on the failure fallback
   always_ff @(posedge clk_i) begin
      if (!rst_b_i || main_sel != main_source_select_o) begin
         meas_cnt_reg  <= 16'h0000;
         meas_slow_reg <= 5'h00;
         meas_run_reg  <= 1'b0;
         freq_rdy_reg  <= 1'b0;
         freq_val_reg  <= 16'h0000;
      end else if (slow_rise) begin
         meas_run_reg <= 1'b1;
         if (meas_run_reg && meas_slow_reg == 5'(MEAS_SLOW_CYC - 1)) begin
            freq_val_reg  <= meas_cnt_reg;
            freq_rdy_reg  <= 1'b1;
            meas_slow_reg <= 5'h00;
            meas_cnt_reg  <= 16'h0000;
         end else if (meas_run_reg) begin
            meas_slow_reg <= meas_slow_reg + 5'h01;
         end
      end else if (meas_run_reg && main_edge && meas_cnt_reg != 16'hffff) begin
         meas_cnt_reg <= meas_cnt_reg + 16'h0001;
      end
   end

   // ***************************************************
   // pll configuration and lock
   // ***************************************************
   logic [5:0] lock_cnt_reg;
   logic       lock_reg, pll_on;
   logic [6:0] pll_div, pll_mul;

   assign pll_div = pll_cfg_reg[PLL_DIV_LSB +: 7];
   assign pll_mul = pll_cfg_reg[PLL_MUL_LSB +: 7];
   assign pll_on  = (pll_div != 7'h00) & (pll_mul != 7'h00);

   // multiplier above its range is held at the top value
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         pll_cfg_reg <= PLL_CFG_RST;
      end else if (wr_en && hit(paddr_i, PLL_CFG_OFS)) begin
         pll_cfg_reg <= {9'h000, (pwdata_i[PLL_MUL_LSB +: 7] > PLL_MUL_MAX)
                        ? PLL_MUL_MAX : pwdata_i[PLL_MUL_LSB +: 7],
                        2'h0, pwdata_i[PLL_CNT_LSB +: 6],
                        1'b0, pwdata_i[PLL_DIV_LSB +: 7]};
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         lock_cnt_reg <= 6'h00;
         lock_reg     <= 1'b0;
      end else if (wr_en && hit(paddr_i, PLL_CFG_OFS)) begin
         lock_cnt_reg <= pwdata_i[PLL_CNT_LSB +: 6];
         lock_reg     <= 1'b0;
      end else if (!pll_on) begin
         lock_reg <= 1'b0;
      end else if (lock_cnt_reg == 6'h00) begin
         lock_reg <= 1'b1;
      end else if (slow_rise) begin
         lock_cnt_reg <= lock_cnt_reg - 6'h01;
      end
   end

   // ***************************************************
   // status, interrupt enable and calibration
   // ***************************************************
   always_comb begin
      status_w               = 32'h0000_0000;
      status_w[ST_XTAL_OK]   = xtal_ok_reg;
      status_w[ST_PLL_LOCK]  = lock_reg;
      status_w[ST_FRC_OK]    = frc_en;
      status_w[ST_SWITCHED]  = switched_reg;
      status_w[ST_FAIL_EV]   = event_reg;
      status_w[ST_FAIL_LIVE] = live_fail_reg;
      status_w[ST_FAULT]     = fault_reg;
      status_w[ST_XT32_ERR]  = x32_err_reg;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         int_en_reg <= 32'h0000_0000;
         rc_cal_reg <= RC_CAL_RST;
      end else if (wr_en) begin
         if (hit(paddr_i, INT_EN_OFS)) int_en_reg <= pwdata_i;
         if (hit(paddr_i, RC_CAL_OFS)) rc_cal_reg <= pwdata_i[2:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) irq_o <= 1'b0;
      else irq_o <= |(status_w & int_en_reg);
   end

   // ***************************************************
   // apb read path, one wait state
   // ***************************************************
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (paddr_i)
         OSC_CTRL_OFS:  rd_mux = osc_ctrl_reg;
         FREQ_MEAS_OFS: rd_mux = {15'h0000, freq_rdy_reg, freq_val_reg};
         PLL_CFG_OFS:   rd_mux = pll_cfg_reg;
         STATUS_OFS:    rd_mux = status_w;
         INT_EN_OFS:    rd_mux = int_en_reg;
         RC_CAL_OFS:    rd_mux = {29'h0000_0000, rc_cal_reg};
         default:       rd_mux = 32'h0000_0000;
      endcase
   end

   // the wait state keeps prdata and pready straight from flops
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
      end else begin
         pready_o  <= psel_i & penable_i & ~pready_o;
         pslverr_o <= psel_i & penable_i & ~pready_o & ~mapped;
         prdata_o  <= (psel_i & penable_i & ~pready_o & ~pwrite_i)
                      ? rd_mux : 32'h0000_0000;
      end
   end

   // ***************************************************
   // clock control outputs
   // ***************************************************
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         crystal_osc_enable_o <= 1'b0;
         fast_rc_enable_o     <= 1'b1;
         rc32_enable_o        <= 1'b0;
         main_source_select_o <= 1'b0;
         master_force_main_o  <= 1'b0;
         pll_enable_o         <= 1'b0;
         pll_input_divider_o  <= 7'h00;
         pll_multiplier_o     <= 7'h00;
         fault_output_o       <= 1'b0;
      end else begin
         crystal_osc_enable_o <= xtal_en;
         fast_rc_enable_o     <= frc_en | fail_pulse;
         rc32_enable_o        <= osc_ctrl_reg[FDET_EN_BIT];
         main_source_select_o <= main_sel & ~fail_pulse;
         master_force_main_o  <= force_main_reg | fail_force_master;
         pll_enable_o         <= pll_on;
         pll_input_divider_o  <= pll_div;
         pll_multiplier_o     <= pll_mul;
         fault_output_o       <= fault_reg | fail_pulse;
      end
   end

endmodule : mcm_main_clock_monitor
`default_nettype wire

// ---- core/mcm_sync.sv ----
// Purpose: two-flop synchroniser for a group of asynchronous levels
// Assumes: inputs change slower than half the clock rate
// Notes:   only the second stage is visible to the user
`timescale 1ns/1ns
`default_nettype none
module mcm_sync #(
   parameter int unsigned W = 1
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_b_i,
   // data
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);

   logic [W-1:0] meta_reg;

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         meta_reg <= '0;
         sync_o   <= '0;
      end else begin
         meta_reg <= async_i;
         sync_o   <= meta_reg;
      end
   end

endmodule : mcm_sync
`default_nettype wire

// ---- include/mcm_pkg.sv ----
// Purpose: constants shared by the main clock monitor and its helpers
// Assumes: 32-bit APB register words, 25 MHz system clock
// Notes:   all offsets are byte addresses
package mcm_pkg;

   // ***************************************************
   // clock and timing
   // ***************************************************
   localparam int unsigned CLK_PERIOD_NS     = 40;
   localparam int unsigned XT32_PERIOD_NS    = 30518;
   localparam int unsigned XT32_NOM_CYC      = XT32_PERIOD_NS / CLK_PERIOD_NS;
   localparam int unsigned XT32_MIN_CYC      = (XT32_NOM_CYC * 9) / 10;
   localparam int unsigned XT32_MAX_CYC      = (XT32_NOM_CYC * 11 + 9) / 10;
   localparam int unsigned XT32_BAD_RUNS     = 4;
   localparam int unsigned FAIL_MIN_EDGES    = 8;
   localparam int unsigned MEAS_SLOW_CYC     = 16;
   localparam int unsigned STARTUP_SCALE     = 8;

   // ***************************************************
   // register offsets
   // ***************************************************
   localparam logic [7:0] OSC_CTRL_OFS   = 8'h00;
   localparam logic [7:0] FREQ_MEAS_OFS  = 8'h04;
   localparam logic [7:0] PLL_CFG_OFS    = 8'h08;
   localparam logic [7:0] STATUS_OFS     = 8'h0c;
   localparam logic [7:0] INT_EN_OFS     = 8'h10;
   localparam logic [7:0] FAULT_CLR_OFS  = 8'h14;
   localparam logic [7:0] RC_CAL_OFS     = 8'h18;

   // ***************************************************
   // osc control fields
   // ***************************************************
   localparam int unsigned XTAL_EN_BIT     = 0;
   localparam int unsigned XT32_MON_BIT    = 2;
   localparam int unsigned FRC_EN_BIT      = 3;
   localparam int unsigned STARTUP_LSB     = 8;
   localparam int unsigned MAIN_SEL_BIT    = 24;
   localparam int unsigned FDET_EN_BIT     = 25;

   // ***************************************************
   // pll, measure and fault clear fields
   // ***************************************************
   localparam int unsigned PLL_DIV_LSB     = 0;
   localparam int unsigned PLL_CNT_LSB     = 8;
   localparam int unsigned PLL_MUL_LSB     = 16;
   localparam logic [6:0]  PLL_MUL_MAX     = 7'h50;
   localparam int unsigned FREQ_RDY_BIT    = 16;
   localparam int unsigned FAULT_OUTPUT_CLEAR_BIT       = 0;

   // ***************************************************
   // status / interrupt enable bits
   // ***************************************************
   localparam int unsigned ST_XTAL_OK      = 0;
   localparam int unsigned ST_PLL_LOCK     = 1;
   localparam int unsigned ST_FRC_OK       = 3;
   localparam int unsigned ST_SWITCHED     = 16;
   localparam int unsigned ST_FAIL_EV      = 18;
   localparam int unsigned ST_FAIL_LIVE    = 19;
   localparam int unsigned ST_FAULT        = 20;
   localparam int unsigned ST_XT32_ERR     = 21;

   // ***************************************************
   // reset values and master selector codes
   // ***************************************************
   localparam logic [31:0] OSC_CTRL_RST   = 32'h0000_0008;
   localparam logic [31:0] PLL_CFG_RST    = 32'h0000_3f00;
   localparam logic [2:0]  RC_CAL_RST     = 3'h0;
   localparam logic [1:0]  CSS_MAIN       = 2'h1;
   localparam logic [1:0]  CSS_PLL        = 2'h2;

endpackage : mcm_pkg

// ---- tb/mcm_main_clock_monitor_properties.sv ----
// Purpose: port-level properties of the main clock monitor
// Assumes: apb master keeps the protocol
// Notes:   bound to every instance of the monitor
`timescale 1ns/1ns
`default_nettype none
module mcm_main_clock_monitor_properties
   import mcm_pkg::*;
(
   // clock, reset and apb
   input wire logic        clk_i,
   input wire logic        rst_b_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [7:0]  paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   // clock controls
   input wire logic        rc32_enable_o,
   input wire logic        fast_rc_enable_o,
   input wire logic        main_source_select_o,
   input wire logic        master_force_main_o,
   input wire logic        fault_output_o,
   input wire logic        pll_enable_o,
   input wire logic [6:0]  pll_input_divider_o,
   input wire logic [6:0]  pll_multiplier_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);
   logic wr_fire;
   assign wr_fire = psel_i && penable_i && pready_o && pwrite_i;
   a_one_wait_state: assert property (psel_i && !penable_i |-> ##2 pready_o)
      else $error("pready late after setup");
   a_ready_pulse: assert property (pready_o |=> !pready_o)
      else $error("pready longer than one cycle");
   a_slverr_ready: assert property (pslverr_o |-> pready_o)
      else $error("pslverr without pready");
   a_rc32_on_enable: assert property (wr_fire && paddr_i == OSC_CTRL_OFS
      && pwdata_i[FDET_EN_BIT] |-> ##2 rc32_enable_o) else $error("rc32 off");
   a_fault_clear_only: assert property ($fell(fault_output_o) |->
      $past(wr_fire, 2) && $past(paddr_i, 2) == FAULT_CLR_OFS)
      else $error("fault dropped without clear");
   a_fail_to_rc: assert property ($rose(fault_output_o) |->
      !main_source_select_o && fast_rc_enable_o) else $error("no rc fallback");
   a_force_main: assert property ($rose(master_force_main_o) |->
      ##[0:2] fault_output_o) else $error("force without failure");
   a_pll_div_off: assert property (pll_input_divider_o == 7'h00 |->
      !pll_enable_o) else $error("pll on with zero divider");
   a_pll_mul_off: assert property (pll_multiplier_o == 7'h00 |->
      !pll_enable_o) else $error("pll on with zero multiplier");
   a_pll_mul_max: assert property (pll_multiplier_o <= PLL_MUL_MAX)
      else $error("multiplier above range");
endmodule : mcm_main_clock_monitor_properties
bind mcm_main_clock_monitor mcm_main_clock_monitor_properties u_props (
   .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .rc32_enable_o(rc32_enable_o),
   .fast_rc_enable_o(fast_rc_enable_o),
   .main_source_select_o(main_source_select_o),
   .master_force_main_o(master_force_main_o),
   .fault_output_o(fault_output_o), .pll_enable_o(pll_enable_o),
   .pll_input_divider_o(pll_input_divider_o),
   .pll_multiplier_o(pll_multiplier_o));
`default_nettype wire

// ---- tb/tb_mcm_main_clock_monitor.sv ----
// Purpose: self-checking bench for the main clock monitor
// Assumes: oscillator edges never meet a rising clk_i edge
// Notes:   ten fast rc rises per slow period
`timescale 1ns/1ns
`default_nettype none
module tb_mcm_main_clock_monitor;
   import mcm_pkg::*;
   logic        clk_i = 1'b0, rst_b_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
   logic        pwrite_i = 1'b0, pready_o, pslverr_o, rerr;
   logic [7:0]  paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0, prdata_o, rdata;
   logic        crystal_clk_i = 1'b0, fast_rc_clk_i = 1'b0, rc32_clk_i = 1'b0;
   logic        slow_clk_i = 1'b0, slow_crystal_clk_i = 1'b0;
   logic        xt_run = 1'b0, sxt_run = 1'b0;
   logic [1:0]  master_source_select_i = 2'h0;
   logic        crystal_osc_enable_o, fast_rc_enable_o, rc32_enable_o, irq_o;
   logic        main_source_select_o, master_force_main_o, pll_enable_o;
   logic [6:0]  pll_input_divider_o, pll_multiplier_o;
   logic        fault_output_o;
   int          miscompares = 0, total_checks = 0, seed = 32'h18ce;
   int          dv, ml, n, sxt_half = 8000;
   mcm_main_clock_monitor u_mcm_main_clock_monitor (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .crystal_clk_i(crystal_clk_i),
      .fast_rc_clk_i(fast_rc_clk_i), .rc32_clk_i(rc32_clk_i),
      .slow_clk_i(slow_clk_i), .slow_crystal_clk_i(slow_crystal_clk_i),
      .master_source_select_i(master_source_select_i),
      .crystal_osc_enable_o(crystal_osc_enable_o),
      .fast_rc_enable_o(fast_rc_enable_o), .rc32_enable_o(rc32_enable_o),
      .main_source_select_o(main_source_select_o),
      .master_force_main_o(master_force_main_o),
      .pll_enable_o(pll_enable_o), .pll_input_divider_o(pll_input_divider_o),
      .pll_multiplier_o(pll_multiplier_o), .fault_output_o(fault_output_o),
      .irq_o(irq_o));
   // ****
   // clocks; a dead crystal just stops
   // ****
   always #20 clk_i = ~clk_i;
   always #120 if (xt_run) crystal_clk_i = ~crystal_clk_i;
   always #200 fast_rc_clk_i = ~fast_rc_clk_i;
   always #2000 slow_clk_i = ~slow_clk_i;
   always #4000 if (rc32_enable_o) rc32_clk_i = ~rc32_clk_i;
   always #(sxt_half) if (sxt_run) slow_crystal_clk_i = ~slow_crystal_clk_i;
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // idle edge first, so psel never changes twice in one step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_i);
      psel_i   <= 1'b1;
      pwrite_i <= w;
      paddr_i  <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (pready_o !== 1'b1 && k < 20);
      rdata = prdata_o;
      rerr  = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
      if (k >= 20) begin
         miscompares++;
         finish_test();
      end
   endtask : apb
   task automatic wait_bit(input logic [7:0] a, input int b);
      int k;
      k = 0;
      do begin
         apb(1'b0, a, 32'h0);
         k++;
      end while (rdata[b] !== 1'b1 && k < 2000);
      if (k >= 2000) begin
         chk(k, 0);
         finish_test();
      end
   endtask : wait_bit
   initial begin
      repeat (16) @(posedge clk_i);
      rst_b_i <= 1'b1;
      apb(1'b0, OSC_CTRL_OFS, 32'h0);
      chk(rdata, OSC_CTRL_RST);
      apb(1'b0, PLL_CFG_OFS, 32'h0);
      chk(rdata, PLL_CFG_RST);
      apb(1'b0, 8'h1c, 32'h0);
      chk({rerr, rdata}, {1'b1, 32'h0});
      chk({irq_o, fast_rc_enable_o, pll_enable_o}, 3'h2);
      $display("reset test done");
      for (int i = 0; i < 3; i++) begin
         dv = $random(seed) & 32'h7f;
         ml = $random(seed) & 32'h7f;
         if (i == 0) dv = dv | 1;
         if (i == 0) ml = ml | 1;
         apb(1'b1, PLL_CFG_OFS, (ml << 16) | 32'h0300 | dv);
         apb(1'b0, STATUS_OFS, 32'h0);
         chk(rdata[ST_PLL_LOCK], 1'b0);
         apb(1'b0, PLL_CFG_OFS, 32'h0);
         chk(rdata[22:16], (ml > 80) ? 80 : ml);
         chk(pll_enable_o, dv != 0 && ml != 0);
         chk({pll_multiplier_o, pll_input_divider_o},
             (((ml > 80) ? 80 : ml) << 7) | dv);
         if (dv != 0 && ml != 0) wait_bit(STATUS_OFS, ST_PLL_LOCK);
      end
      $display("pll test done");
      wait_bit(FREQ_MEAS_OFS, FREQ_RDY_BIT);
      apb(1'b0, FREQ_MEAS_OFS, 32'h0);
      chk(rdata[15:0], MEAS_SLOW_CYC * 10);
      apb(1'b1, OSC_CTRL_OFS, 32'h0200_0008);
      repeat (600) @(posedge clk_i);
      chk({crystal_osc_enable_o, rc32_enable_o, fault_output_o}, 3'h2);
      xt_run = 1'b1;
      apb(1'b1, OSC_CTRL_OFS, 32'h0200_0109);
      wait_bit(STATUS_OFS, ST_XTAL_OK);
      chk(crystal_osc_enable_o, 1'b1);
      apb(1'b1, OSC_CTRL_OFS, 32'h0300_0109);
      wait_bit(STATUS_OFS, ST_SWITCHED);
      master_source_select_i <= CSS_PLL;
      apb(1'b1, INT_EN_OFS, 32'h1 << ST_FAIL_EV);
      xt_run = 1'b0;
      n = 0;
      while (main_source_select_o !== 1'b0 && n < 604) begin
         @(posedge clk_i);
         n++;
      end
      chk(n < 604, 1'b1);
      repeat (2) @(posedge clk_i);
      chk({fault_output_o, fast_rc_enable_o, master_force_main_o}, 3'h7);
      chk(irq_o, 1'b1);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk(rdata[ST_FAULT:ST_FAIL_EV], 3'h7);
      apb(1'b1, FAULT_CLR_OFS, 32'h1);
      repeat (2) @(posedge clk_i);
      chk(fault_output_o, 1'b1);
      xt_run = 1'b1;
      master_source_select_i <= CSS_MAIN;
      repeat (500) @(posedge clk_i);
      apb(1'b0, STATUS_OFS, 32'h0);
      repeat (2) @(posedge clk_i);
      chk({irq_o, master_force_main_o}, 2'h0);
      apb(1'b1, FAULT_CLR_OFS, 32'h1);
      repeat (2) @(posedge clk_i);
      chk(fault_output_o, 1'b0);
      $display("failure test done");
      apb(1'b1, INT_EN_OFS, 32'h1 << ST_XT32_ERR);
      sxt_run = 1'b1;
      apb(1'b1, OSC_CTRL_OFS, 32'h0200_010d);
      repeat (900) @(posedge clk_i);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk(rdata[ST_XT32_ERR], 1'b0);
      wait_bit(STATUS_OFS, ST_XT32_ERR);
      sxt_half = 15240;
      repeat (2000) @(posedge clk_i);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk({rdata[ST_XT32_ERR], irq_o}, 2'h3);
      apb(1'b1, OSC_CTRL_OFS, 32'h0200_0109);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk({rdata[ST_XT32_ERR], rdata[ST_FRC_OK]}, 2'h1);
      apb(1'b1, RC_CAL_OFS, 32'h5);
      apb(1'b0, RC_CAL_OFS, 32'h0);
      chk(rdata, 32'h5);
      $display("slow monitor test done");
      finish_test();
   end
endmodule : tb_mcm_main_clock_monitor
`default_nettype wire
